/* verilog/dic_pkg.sv */
// Package for the debug ID code protection gate
package dic_pkg;

  // Register map (byte addresses, one word per register)
  localparam logic [7:0] DIC_ADR_ID0   = 8'h00;
  localparam logic [7:0] DIC_ADR_ID1   = 8'h04;
  localparam logic [7:0] DIC_ADR_ID2   = 8'h08;
  localparam logic [7:0] DIC_ADR_ID3   = 8'h0C;
  localparam logic [7:0] DIC_ADR_CTRL  = 8'h10;
  localparam logic [7:0] DIC_ADR_STAT  = 8'h14;

  // Stored code and patterns
  localparam logic [127:0] DIC_ID_RESET  = 128'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF_FFFF;
  localparam logic [127:0] DIC_ERASE_PAT = 128'h414C_6552_4153_45FF_FFFF_FFFF_FFFF_FFFF;
  localparam int           DIC_MODE_HI   = 127;
  localparam int           DIC_MODE_LO   = 126;

  // Control register field positions
  localparam int DIC_CTRL_LOAD = 0;
  localparam int DIC_CTRL_CLR  = 1;

  // Connection evaluation states
  typedef enum logic [2:0]
  {
    DIC_ST_IDLE,
    DIC_ST_EVAL,
    DIC_ST_GRANT,
    DIC_ST_WAIT,
    DIC_ST_DENY
  } dic_state_t;

  // Connection request from the tool side
  typedef struct packed
  {
    logic         req;
    logic         from_dbg;
    logic [127:0] code;
  } dic_conn_t;

  // Whole module state
  typedef struct packed
  {
    logic [127:0] id;
    logic [127:0] stage;
    logic [127:0] code;
    logic         from_dbg;
    dic_state_t   st;
    logic         granted;
    logic         wait_st;
    logic         erase;
    logic [31:0]  rdat;
    logic         ack;
  } dic_regs_t;

endpackage

/* verilog/dic_gate.sv */
// Debug ID code protection gate with Wishbone register access
// Behaviour
// [R1] A 128-bit stored ID code authenticates every debugger or programmer before access.
// [R2] The connecting tool supplies an ID value that decides acceptance.
// [R3] Serial and USB boot programming connections are checked exactly like the debugger. The code honours the locked-mode erase pattern from the debugger only.
// [R4] An all-0xFF stored code disables protection and always grants the connection.
// [R5] With bits 127 and 126 set and not all 0xFF, a matching code grants the connection.
// [R6] With bit 127 set and a mismatching code, the gate enters the protection wait state.
// [R7] In mode 11 the erase pattern erases user flash and sets the stored code to all ones.
// [R8] Flash erase is suppressed when the permanent-lock bit is zero or the security MPU is on.
// [R9] With bit 127 set and bit 126 clear, only a matching code grants the connection.
// [R10] With bit 127 clear, every code mismatches and all connections are refused.
// [R11] With bit 127 clear, the erase pattern from the debugger still erases and resets the code.
// [R12] Locked mode without erase leaves the device unreachable for debug and programming.
// [R13] Three settings exist: ID ignored, checked with all-erase, checked without all-erase. The code adds a fourth, locked, when bit 127 is clear.
// [R14] Mode bits and the all-0xFF test are evaluated at connection time before any grant.
`timescale 1ns/1ps
module dic_gate
  import dic_pkg::*;
(
  // Clock and reset
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  // Wishbone slave
  input  wire logic         i_wb_cyc,
  input  wire logic         i_wb_stb,
  input  wire logic         i_wb_we,
  input  wire logic [7:0]   i_wb_adr,
  input  wire logic [3:0]   i_wb_sel,
  input  wire logic [31:0]  i_wb_dat,
  output logic      [31:0]  o_wb_dat,
  output logic              o_wb_ack,
  // Connection attempt from tool logic (same clock)
  input  wire dic_conn_t    i_conn,
  // Flash protection status
  input  wire logic         i_access_window_permanent_lock,
  input  wire logic         i_sec_mpu_enable,
  // Results
  output logic              o_access_granted,
  output logic              o_id_wait,
  output logic              o_flash_erase
);

  dic_regs_t q;
  dic_regs_t d;

  // Bus hit and decode nets

  logic         wb_hit;
  logic         all_ff;
  logic         code_match;
  logic         erase_hit;
  logic         erase_ok;
  logic [31:0]  wmask;

  // Ack high blocks a second hit on the same request
  assign wb_hit     = i_wb_cyc && i_wb_stb && !q.ack;
  assign all_ff     = (q.id == DIC_ID_RESET);                                  // R4
  assign code_match = (q.code == q.id);                                        // R1
  assign erase_hit  = (q.code == DIC_ERASE_PAT);                               // R7 R11
  assign erase_ok   = i_access_window_permanent_lock && !i_sec_mpu_enable;     // R8

  // Byte-lane mask from sel
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      wmask[b*8 +: 8] = {8{i_wb_sel[b]}};
    end
  end

  // Next-state logic
  always_comb
  begin
    // Ack follows a hit; erase and read data are one-cycle pulses
    d       = q;
    d.ack   = wb_hit;
    d.erase = 1'b0;
    d.rdat  = 32'h0000_0000;
    // Register reads return stored code and status
    if (wb_hit && !i_wb_we)
    begin
      case (i_wb_adr)
        DIC_ADR_ID0:  d.rdat = q.id[31:0];
        DIC_ADR_ID1:  d.rdat = q.id[63:32];
        DIC_ADR_ID2:  d.rdat = q.id[95:64];
        DIC_ADR_ID3:  d.rdat = q.id[127:96];
        DIC_ADR_STAT: d.rdat = {29'h0000_0000, q.wait_st, q.granted, all_ff};
        default:      d.rdat = 32'h0000_0000;
      endcase
    end
    // Writes fill the staging image; a load copies it to the stored code
    if (wb_hit && i_wb_we)
    begin
      case (i_wb_adr)
        DIC_ADR_ID0:
          d.stage[31:0]   = (q.stage[31:0] & ~wmask) | (i_wb_dat & wmask);
        DIC_ADR_ID1:
          d.stage[63:32]  = (q.stage[63:32] & ~wmask) | (i_wb_dat & wmask);
        DIC_ADR_ID2:
          d.stage[95:64]  = (q.stage[95:64] & ~wmask) | (i_wb_dat & wmask);
        DIC_ADR_ID3:
          d.stage[127:96] = (q.stage[127:96] & ~wmask) | (i_wb_dat & wmask);
        DIC_ADR_CTRL:
        begin
          if (i_wb_sel[0] && i_wb_dat[DIC_CTRL_LOAD])
          begin
            d.id = q.stage;
          end
          if (i_wb_sel[0] && i_wb_dat[DIC_CTRL_CLR])
          begin
            d.granted = 1'b0;
            d.wait_st = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
    // Connection evaluation
    case (q.st)
      DIC_ST_IDLE:
      begin
        if (i_conn.req)                                                        // R2 R3
        begin
          d.st       = DIC_ST_EVAL;
          d.granted  = 1'b0;
          d.wait_st  = 1'b0;
          // Capture at request so evaluation sees a stable code
          d.code     = i_conn.code;
          d.from_dbg = i_conn.from_dbg;
        end
      end
      DIC_ST_EVAL:
      begin
        // Decide only from the code held now, never a stale grant
        if (all_ff)                                                            // R4 R13 R14
        begin
          d.st      = DIC_ST_GRANT;
          d.granted = 1'b1;
        end
        else if (q.id[DIC_MODE_HI])
        begin
          if (code_match)                                                      // R5 R9
          begin
            d.st      = DIC_ST_GRANT;
            d.granted = 1'b1;
          end
          else
          begin
            d.st      = DIC_ST_WAIT;                                           // R6
            d.wait_st = 1'b1;
            // Code resets even when the flash erase itself is blocked
            if (q.id[DIC_MODE_LO] && erase_hit)                                // R7
            begin
              d.id    = DIC_ID_RESET;
              d.erase = erase_ok;                                              // R8
            end
          end
        end
        else
        begin
          // Refused outright: no wait state, only a debugger erase escape
          d.st = DIC_ST_DENY;                                                  // R10 R12
          if (erase_hit && q.from_dbg)                                         // R11
          begin
            d.id    = DIC_ID_RESET;
            d.erase = erase_ok;                                                // R8
          end
        end
      end
      // Outcome stands until the tool drops its request
      DIC_ST_GRANT, DIC_ST_WAIT, DIC_ST_DENY:
      begin
        if (!i_conn.req)
        begin
          d.st = DIC_ST_IDLE;
        end
      end
      default:
      begin
        d.st = DIC_ST_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q.id      <= DIC_ID_RESET;
      q.st      <= DIC_ST_IDLE;
      q.granted <= 1'b0;
      q.wait_st <= 1'b0;
      q.erase   <= 1'b0;
      q.rdat    <= 32'h0000_0000;
      q.ack     <= 1'b0;
      q.stage    <= DIC_ID_RESET;
      q.code     <= 128'h0;
      q.from_dbg <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign o_wb_dat         = q.rdat;
  assign o_wb_ack         = q.ack;
  assign o_access_granted = q.granted;
  assign o_id_wait        = q.wait_st;
  assign o_flash_erase    = q.erase;

  // Grant checks, one cycle after the request or after evaluation
  a_grant_all_ff: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R4
    (q.st == DIC_ST_EVAL && all_ff)
      |=> o_access_granted)
    else $error("all-ones code did not grant");

  a_grant_match: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R5
    (q.st == DIC_ST_EVAL && q.id[127] && code_match)
      |=> o_access_granted)
    else $error("matching code did not grant");

  a_mode10_match: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R9
    (q.st == DIC_ST_EVAL && q.id[127:126] == 2'b10)
      |=> (o_access_granted == $past(code_match)))
    else $error("checked mode grant differs from match");

  a_eval_first: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R14
    (q.st == DIC_ST_IDLE && i_conn.req)
      |=> (q.st == DIC_ST_EVAL && !o_access_granted && !o_id_wait))
    else $error("access changed before evaluation");

  // Refusal checks; a stale grant must never leak into a refusal
  a_wait_mismatch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R6
    (q.st == DIC_ST_EVAL && q.id[127] && !code_match && !all_ff)
      |=> (o_id_wait && !o_access_granted))
    else $error("mismatch did not enter wait");

  a_one_outcome: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R6
    o_access_granted
      |-> !o_id_wait)
    else $error("grant and wait both set");

  a_lock_deny: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R10
    (q.st == DIC_ST_EVAL && !q.id[127])
      |=> !o_access_granted [*2])
    else $error("locked mode granted access");

  a_deny_nowait: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R10
    (q.st == DIC_ST_EVAL && !q.id[127])
      |=> (q.st == DIC_ST_DENY && !o_id_wait))
    else $error("locked mode entered wait");

  // Erase checks; the code reset stands even when flash erase is blocked
  a_erase_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R7
    (q.st == DIC_ST_EVAL && q.id[127:126] == 2'b11 && erase_hit && !all_ff)
      |=> (q.id == DIC_ID_RESET))
    else $error("erase pattern did not reset code");

  a_erase_allowed: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R7
    (q.st == DIC_ST_EVAL && q.id[127:126] == 2'b11 && erase_hit && !all_ff && erase_ok)
      |=> o_flash_erase)
    else $error("permitted erase did not pulse");

  a_erase_block: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R8
    o_flash_erase
      |-> ($past(i_access_window_permanent_lock) && !$past(i_sec_mpu_enable)))
    else $error("erase not suppressed by lock or MPU");

  a_erase_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R8
    o_flash_erase
      |=> !o_flash_erase)
    else $error("erase request held two cycles");

  a_erase_dbg_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R11
    (q.st == DIC_ST_EVAL && !q.id[127] && erase_hit && q.from_dbg)
      |=> (q.id == DIC_ID_RESET))
    else $error("debugger erase did not reset code");

  a_erase_dbg_only: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R11
    (q.st == DIC_ST_EVAL && !q.id[127] && !q.from_dbg)
      |=> !o_flash_erase)
    else $error("programmer erased in locked mode");

  a_noerase_mode: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n) // R12
    (q.st == DIC_ST_EVAL && q.id[127:126] == 2'b10)
      |=> !o_flash_erase)
    else $error("erase in no-erase mode");

  // Bus checks
  a_wb_ack_once: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_wb_ack
      |=> !o_wb_ack)
    else $error("ack held two cycles");

  a_rdat_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_wb_ack
      |-> (o_wb_dat == 32'h0000_0000))
    else $error("read data outside ack");

endmodule

/* bench/dic_tool_model.sv */
// External debug tool model that offers ID codes to the gate
`timescale 1ns/1ps
module dic_tool_model
  import dic_pkg::*;
(
  // Clock
  input  wire logic i_sys_clk,
  // Connection lines toward the gate
  output dic_conn_t o_conn
);
  // Idle lines at time zero
  initial o_conn = '0;
  // One attempt; released code lines invert so stale data never looks valid
  task automatic connect(input logic [127:0] code, input logic dbg);
    @(posedge i_sys_clk);
    o_conn <= '{req: 1'b1, from_dbg: dbg, code: code};
    repeat (4) @(posedge i_sys_clk);
    o_conn <= '{req: 1'b0, from_dbg: ~dbg, code: ~code};
    repeat (3) @(posedge i_sys_clk);
  endtask
endmodule

/* bench/debug_id_code_protection_test.sv */
// Self-checking bench for the debug ID code gate
`timescale 1ns/1ps
module debug_id_code_protection_test
  import dic_pkg::*;
;
  logic         clk, rst_n, cyc, stb, we, ack, lock, mpu, grant, wt, ers;
  logic [7:0]   adr;
  logic [3:0]   sel;
  logic [31:0]  wdat, rdat, q;
  logic [127:0] exp_id, code, r;
  dic_conn_t    conn;
  int           n_mismatch, comparisons, n_erase;

  dic_tool_model u_tool (.i_sys_clk(clk), .o_conn(conn));
  dic_gate u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_conn(conn), .i_access_window_permanent_lock(lock),
    .i_sec_mpu_enable(mpu), .o_access_granted(grant), .o_id_wait(wt),
    .o_flash_erase(ers));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Erase pulses counted, since they stand one cycle only
  always @(posedge clk) n_erase <= n_erase + int'(ers === 1'b1);
  // Watchdog well beyond the expected run
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [127:0] g, input logic [127:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Classic cycle; no latency assumed, only the watchdog guards a hang
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, 4'hf, a, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  function automatic logic [127:0] rnd();
    return {$urandom, $urandom, $urandom, $urandom};
  endfunction

  // Reference model: {grant, wait, erase}; also tracks the stored code
  function automatic logic [2:0] model(input logic [127:0] c, input logic d);
    logic [2:0] x;
    x = 3'b000;
    if (exp_id == DIC_ID_RESET) x[2] = 1'b1;
    else if (exp_id[DIC_MODE_HI])
    begin
      if (c == exp_id) x[2] = 1'b1; else x[1] = 1'b1;
      if (exp_id[DIC_MODE_LO] && c == DIC_ERASE_PAT) x[0] = lock & ~mpu;
      if (exp_id[DIC_MODE_LO] && c == DIC_ERASE_PAT) exp_id = DIC_ID_RESET;
    end
    else if (d && c == DIC_ERASE_PAT)
    begin
      x[0] = lock & ~mpu;
      exp_id = DIC_ID_RESET;
    end
    return x;
  endfunction

  task automatic load(input logic [127:0] c);
    for (int i = 0; i < 4; i++) wb(1'b1, 8'(4 * i), c[32 * i +: 32]);
    wb(1'b1, DIC_ADR_CTRL, 32'h0000_0001);
    exp_id = c;
  endtask

  task automatic attempt(input logic [127:0] c, input logic d);
    int         e0;
    logic [2:0] x;
    e0 = n_erase;
    u_tool.connect(c, d);
    x = model(c, d);
    chk({grant, wt, n_erase != e0}, x);
    wb(1'b0, DIC_ADR_STAT, 32'h0000_0000);
    chk(q, {x[1], x[2], exp_id == DIC_ID_RESET});
    for (int i = 0; i < 4; i++)
    begin
      wb(1'b0, 8'(4 * i), '0);
      chk(q, exp_id[32 * i +: 32]);
    end
  endtask

  // Main sequence: reset, defaults, then every mode against every erase case
  initial
  begin
    {rst_n, cyc, stb, we, sel, adr, wdat, lock, mpu} = {48'd0, 2'b10};
    {n_mismatch, comparisons, n_erase} = 0;
    exp_id = DIC_ID_RESET;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    void'($urandom(32'h18b5_5964));
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk(q, 0);
    wb(1'b0, DIC_ADR_STAT, 32'h0000_0000);
    chk(q, 1);
    attempt(rnd(), 1'b0);
    for (int m = 3; m >= 0; m--)
      for (int k = 0; k < 4; k++)
      begin
        r = rnd();
        code = {2'(m), r[125:0]};
        load(code);
        attempt(code, k[0]);
        attempt(~code, k[0]);
        lock <= (k != 1);
        mpu <= (k == 2);
        attempt(DIC_ERASE_PAT, k != 3);
        lock <= 1'b1;
        mpu <= 1'b0;
        wb(1'b1, DIC_ADR_CTRL, 32'h0000_0002);
        chk({grant, wt}, 0);
        $display("test mode %0d case %0d done", m, k);
      end
    tally_and_finish();
  end
endmodule
